// file: rtl/enl_pkg.sv
package enl_pkg;

    // ==========================================================
    // Address map
    localparam logic [31:0] CS3_BASE        = 32'h4000_0000;
    localparam logic [31:0] CS3_LAST        = 32'h4fff_ffff;
    localparam int          ALE_ADDR_BIT    = 21;
    localparam int          CLE_ADDR_BIT    = 22;

    // ==========================================================
    // Data lanes
    localparam int          LANE_W          = 16;
    localparam int          BUS_W           = 32;

    // ==========================================================
    // Reset values of the configuration bits, extra DDR port count
    localparam logic        UPPER_LANE_RST  = 1'b0;
    localparam logic        MULTIPORT_RST   = 1'b0;
    localparam logic        CS1_ASSIGN_RST  = 1'b0;
    localparam logic        CS3_ASSIGN_RST  = 1'b0;
    localparam int          DDR_EXTRA_PORTS = 3;

    // ==========================================================
    // Boot chip select defaults
    localparam logic        BOOT_BYTE_SEL   = 1'b1;
    localparam logic [1:0]  BOOT_WIDTH_16   = 2'h1;
    localparam logic        BOOT_CS_CTRL    = 1'b1;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic nand_upper_lane_select;
        logic ddr_multiport_enable;
        logic cs1_sdram_assign;
        logic cs3_nand_assign;
    } enl_cfg_t;

    typedef struct packed {
        logic       byte_select;
        logic [1:0] data_width;
        logic       cs_controlled_rw;
    } enl_boot_t;

    typedef struct packed {
        logic read_strobe;
        logic write_strobe;
        logic ale;
        logic cle;
    } enl_nand_ctl_t;

endpackage

// file: rtl/enl_lane_mux.sv
`timescale 1ns/1ps

module enl_lane_mux #(
    parameter int LANE_W = 16
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Control
    input  wire logic                upper_i,
    input  wire logic                nand_sel_i,
    input  wire logic                write_i,
    // Controller side
    input  wire logic [LANE_W-1:0]   wdata_i,
    output logic      [LANE_W-1:0]   rdata_o,
    // Pin side
    input  wire logic [2*LANE_W-1:0] pad_d_i,
    output logic      [2*LANE_W-1:0] pad_d_o,
    output logic      [2*LANE_W-1:0] pad_d_oe_o
);

    logic [LANE_W-1:0]   rdata_nxt;
    logic [LANE_W-1:0]   rdata_r;
    logic [2*LANE_W-1:0] d_nxt;
    logic [2*LANE_W-1:0] d_r;
    logic [2*LANE_W-1:0] oe_nxt;
    logic [2*LANE_W-1:0] oe_r;

    // ==========================================================
    // Lane steering
    always_comb begin
        rdata_nxt = upper_i ? pad_d_i[2*LANE_W-1:LANE_W] : pad_d_i[LANE_W-1:0];
        d_nxt     = upper_i ? {wdata_i, {LANE_W{1'b0}}} : {{LANE_W{1'b0}}, wdata_i};
        oe_nxt    = '0;
        if (nand_sel_i && write_i) begin
            // Only the selected half is driven, the other lanes stay free
            oe_nxt = upper_i ? {{LANE_W{1'b1}}, {LANE_W{1'b0}}}
                             : {{LANE_W{1'b0}}, {LANE_W{1'b1}}};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= '0;
            d_r     <= '0;
            oe_r    <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            d_r     <= d_nxt;
            oe_r    <= oe_nxt;
        end
    end

    assign rdata_o    = rdata_r;
    assign pad_d_o    = d_r;
    assign pad_d_oe_o = oe_r;

endmodule

// file: rtl/enl_nand_glue.sv
`timescale 1ns/1ps
// Overview of operation
// - Lane bit picks lower or upper data lanes
// - Reset selects lower lanes, bit reads zero
// - Multiport bit opens three extra DDR ports
// - NAND strobes and write drive active only once assigned; CS3 select decodes always
// - Chip select three decodes 0x40000000..0x4fffffff
// - Controller strobes copied to NAND strobes
// - Strobes drop when address leaves region
// - A21 is ALE, A22 is CLE
// - CE and ready/busy handled by GPIO
// - CS1 assign bit hands CS1 to DDR
// - CS3 assign bit hands CS3 to NAND
// - Boot chip select defaults 16-bit, byte select

module enl_nand_glue #(
    parameter int LANE_W = enl_pkg::LANE_W
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Configuration writes
    input  wire logic                    cfg_we_i,
    input  wire enl_pkg::enl_cfg_t       cfg_wdata_i,
    output enl_pkg::enl_cfg_t            cfg_o,
    // Static memory controller side
    input  wire logic [31:0]             smc_addr_i,
    input  wire logic                    smc_rd_i,
    input  wire logic                    smc_wr_i,
    input  wire logic [LANE_W-1:0]       smc_wdata_i,
    output logic      [LANE_W-1:0]       smc_rdata_o,
    // NAND pins
    output enl_pkg::enl_nand_ctl_t       nand_ctl_o,
    output logic                         chip_select_three_o,
    input  wire logic [2*LANE_W-1:0]     pad_d_i,
    output logic      [2*LANE_W-1:0]     pad_d_o,
    output logic      [2*LANE_W-1:0]     pad_d_oe_o,
    // Memory controller routing
    output logic                         cs1_to_ddr_o,
    output logic [enl_pkg::DDR_EXTRA_PORTS-1:0] ddr_port_en_o,
    output enl_pkg::enl_boot_t           boot_cfg_o
);

    // Lane width must leave both halves inside the 32 data lines
    if (LANE_W < 1 || 2 * LANE_W > enl_pkg::BUS_W) begin : g_bad_lane_w
        $error("LANE_W out of range");
    end

    enl_pkg::enl_cfg_t      cfg_r;
    enl_pkg::enl_cfg_t      cfg_nxt;
    enl_pkg::enl_nand_ctl_t ctl_r;
    enl_pkg::enl_nand_ctl_t ctl_nxt;
    logic                   cs3_r;
    logic                   cs3_nxt;
    logic                   in_cs3;

    // ==========================================================
    // Configuration bits
    always_comb begin
        cfg_nxt = cfg_r;
        if (cfg_we_i) begin
            // Lane choice is taken as written; keeping it legal with shared
            // devices or full-width SDRAM is left to software
            cfg_nxt = cfg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r <= '{nand_upper_lane_select: enl_pkg::UPPER_LANE_RST,
                       ddr_multiport_enable:   enl_pkg::MULTIPORT_RST,
                       cs1_sdram_assign:       enl_pkg::CS1_ASSIGN_RST,
                       cs3_nand_assign:        enl_pkg::CS3_ASSIGN_RST};
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ==========================================================
    // Chip select three decode and strobes
    assign in_cs3 = (smc_addr_i >= enl_pkg::CS3_BASE)
                 && (smc_addr_i <= enl_pkg::CS3_LAST);

    always_comb begin
        cs3_nxt = in_cs3;
        ctl_nxt = '0;
        if (cfg_r.cs3_nand_assign && in_cs3) begin
            ctl_nxt.read_strobe  = smc_rd_i;
            ctl_nxt.write_strobe = smc_wr_i;
            // Cycle type comes only from the offset bits, no extra control
            ctl_nxt.ale = smc_addr_i[enl_pkg::ALE_ADDR_BIT];
            ctl_nxt.cle = smc_addr_i[enl_pkg::CLE_ADDR_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_r <= '0;
            cs3_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            cs3_r <= cs3_nxt;
        end
    end

    // Strobes are gated again combinationally so they fall in the very
    // cycle the address leaves the region, not one later
    always_comb begin
        nand_ctl_o              = ctl_r;
        nand_ctl_o.read_strobe  = ctl_r.read_strobe && in_cs3;
        nand_ctl_o.write_strobe = ctl_r.write_strobe && in_cs3;
    end

    // CE and ready/busy live on GPIO; only the decoded select leaves here
    assign chip_select_three_o = cs3_r;

    // ==========================================================
    // Data lanes
    enl_lane_mux #(
        .LANE_W (LANE_W)
    ) u_lane_mux (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .upper_i    (cfg_r.nand_upper_lane_select),
        .nand_sel_i (cfg_r.cs3_nand_assign && in_cs3),
        .write_i    (smc_wr_i),
        .wdata_i    (smc_wdata_i),
        .rdata_o    (smc_rdata_o),
        .pad_d_i    (pad_d_i),
        .pad_d_o    (pad_d_o),
        .pad_d_oe_o (pad_d_oe_o)
    );

    // ==========================================================
    // Routing outputs
    assign cfg_o         = cfg_r;
    assign cs1_to_ddr_o  = cfg_r.cs1_sdram_assign;
    // Single data rate parts must not see this; nothing here checks the type
    assign ddr_port_en_o = {enl_pkg::DDR_EXTRA_PORTS{cfg_r.ddr_multiport_enable}};

    assign boot_cfg_o = '{byte_select:      enl_pkg::BOOT_BYTE_SEL,
                          data_width:       enl_pkg::BOOT_WIDTH_16,
                          cs_controlled_rw: enl_pkg::BOOT_CS_CTRL};

endmodule

// file: tb/enl_nand_sva.sv
`timescale 1ns/1ps
module enl_nand_sva #(
    parameter int LANE_W = 16
) (
    input wire logic                             clk_i,
    input wire logic                             rst_i,
    input wire logic                             cfg_we_i,
    input wire enl_pkg::enl_cfg_t                cfg_wdata_i,
    input wire enl_pkg::enl_cfg_t                cfg_o,
    input wire logic [31:0]                      smc_addr_i,
    input wire logic                             smc_rd_i,
    input wire logic                             smc_wr_i,
    input wire enl_pkg::enl_nand_ctl_t           nand_ctl_o,
    input wire logic                             chip_select_three_o,
    input wire logic [2*LANE_W-1:0]              pad_d_oe_o,
    input wire logic [enl_pkg::DDR_EXTRA_PORTS-1:0] ddr_port_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic in_rg;
    assign in_rg = smc_addr_i >= enl_pkg::CS3_BASE && smc_addr_i <= enl_pkg::CS3_LAST;
    // ==========================================================
    // Strobe path
    sequence s_req(logic s);
        s && in_rg && cfg_o.cs3_nand_assign ##1 in_rg;
    endsequence
    a_rd_copy: assert property (s_req(smc_rd_i) |-> nand_ctl_o.read_strobe)
        else $error("read strobe not copied");
    a_wr_copy: assert property (s_req(smc_wr_i) |-> nand_ctl_o.write_strobe)
        else $error("write strobe not copied");
    a_strobe_cut: assert property (!in_rg |-> !nand_ctl_o.read_strobe && !nand_ctl_o.write_strobe)
        else $error("strobe outside region");
    a_latch_bits: assert property ((nand_ctl_o.ale |-> $past(smc_addr_i[21]))
        and (nand_ctl_o.cle |-> $past(smc_addr_i[22])))
        else $error("latch enable without address bit");
    a_unassigned_quiet: assert property (!$past(cfg_o.cs3_nand_assign) |-> nand_ctl_o == '0)
        else $error("nand active while unassigned");
    a_cs3_decode: assert property (chip_select_three_o |-> $past(in_rg))
        else $error("chip select three outside region");
    // ==========================================================
    // Configuration
    a_cfg_load: assert property (cfg_we_i |=> cfg_o == $past(cfg_wdata_i))
        else $error("config not loaded");
    a_mport_ports: assert property (ddr_port_en_o == {3{cfg_o.ddr_multiport_enable}})
        else $error("multiport enables wrong");
    a_upper_oe: assert property (|pad_d_oe_o[2*LANE_W-1:LANE_W]
        |-> $past(cfg_o.nand_upper_lane_select) && $past(smc_wr_i))
        else $error("upper lanes driven wrongly");
endmodule

bind enl_nand_glue enl_nand_sva #(.LANE_W(LANE_W)) enl_nand_sva_inst (.*);

// file: tb/enl_flash_model.sv
`timescale 1ns/1ps
module enl_flash_model (
    input  wire logic                   clk_i,
    input  wire enl_pkg::enl_nand_ctl_t ctl_i,
    input  wire logic                   upper_i,
    input  wire logic [15:0]            rd_word_i,
    input  wire logic [31:0]            d_i,
    input  wire logic [31:0]            oe_i,
    output logic      [31:0]            pad_o,
    output logic      [15:0]            wr_word_o
);
    logic [31:0] junk = 32'h5a5a_c3c3;
    logic [31:0] drv;
    // Released lines toggle so stale data cannot pass for a read
    always @(posedge clk_i) junk <= ~junk;
    assign drv = !ctl_i.read_strobe ? junk :
                 upper_i ? {rd_word_i, junk[15:0]} : {junk[31:16], rd_word_i};
    // Ready/busy and CE sit on GPIO lines that the bench never polls here
    assign pad_o = (d_i & oe_i) | (drv & ~oe_i);
    always @(posedge clk_i) if (ctl_i.write_strobe) wr_word_o <= upper_i ? pad_o[31:16] : pad_o[15:0];
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, rst_i = 1, cfg_we_i = 0, smc_rd_i = 0, smc_wr_i = 0;
    logic chip_select_three_o, cs1_to_ddr_o;
    logic [2:0] ddr_port_en_o;
    enl_pkg::enl_cfg_t cfg_wdata_i = '0, cfg_o;
    enl_pkg::enl_nand_ctl_t nand_ctl_o;
    enl_pkg::enl_boot_t boot_cfg_o;
    logic [31:0] smc_addr_i = '0, pad_d_i, pad_d_o, pad_d_oe_o;
    logic [15:0] smc_wdata_i = '0, smc_rdata_o, rd_word = '0, wr_word, seed = 16'h739f;
    logic [31:0] corner [4] = '{32'h3fff_ffff, 32'h4000_0000, 32'h4fff_ffff, 32'h5000_0000};
    int n_fail = 0, n_compared = 0, cyc = 0;

    enl_nand_glue enl_nand_glue_inst (.*);
    enl_flash_model enl_flash_model_inst (.clk_i(clk_i), .ctl_i(nand_ctl_o),
        .upper_i(cfg_o.nand_upper_lane_select), .rd_word_i(rd_word), .d_i(pad_d_o),
        .oe_i(pad_d_oe_o), .pad_o(pad_d_i), .wr_word_o(wr_word));

    initial forever #5 clk_i = ~clk_i;
    // Whole run needs a few hundred cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            give_verdict;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic judge(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
        judge({24'h0, got}, {24'h0, exp});
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        judge(got, exp);
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // One configured access, then a live region exit
    task automatic xfer(input enl_pkg::enl_cfg_t c, input logic [31:0] a, input logic wr);
        logic go;
        go = c.cs3_nand_assign && a >= enl_pkg::CS3_BASE && a <= enl_pkg::CS3_LAST;
        @(negedge clk_i);
        cfg_we_i = 1;
        cfg_wdata_i = c;
        @(negedge clk_i);
        cfg_we_i = 0;
        smc_addr_i = a;
        smc_rd_i = !wr;
        smc_wr_i = wr;
        seed = lfsr(seed);
        smc_wdata_i = seed;
        seed = lfsr(seed);
        rd_word = seed;
        chk_word(32'(cfg_o), 32'(c));
        chk_flag({cs1_to_ddr_o, ddr_port_en_o}, {c.cs1_sdram_assign, {3{c[2]}}});
        repeat (3) @(negedge clk_i);
        chk_flag(nand_ctl_o, {go & !wr, go & wr, go & a[21], go & a[22]});
        chk_word(pad_d_oe_o, !(go && wr) ? 32'h0 : c[3] ? 32'hffff_0000 : 32'h0000_ffff);
        if (go) chk_word(wr ? wr_word : smc_rdata_o, wr ? smc_wdata_i : rd_word);
        smc_addr_i = 32'h5000_0000;
        #1;
        chk_flag(nand_ctl_o[3:2], 8'h0);
        smc_rd_i = 0;
        smc_wr_i = 0;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i) rst_i = 0;
        chk_word(32'(cfg_o), 32'h0);
        chk_flag(boot_cfg_o, {4'h0, enl_pkg::BOOT_BYTE_SEL, enl_pkg::BOOT_WIDTH_16, enl_pkg::BOOT_CS_CTRL});
        foreach (corner[i]) xfer(4'(4 * i + 1), corner[i], i[0]);
        // The flash is the only device and the partner is DDR-class, so any lane or
        // multiport setting is legal here; bus width is the controller's concern
        repeat (40) begin
            seed = lfsr(seed);
            xfer(seed[3:0], {seed[15:13] == 0 ? 4'h3 : 4'h4, seed[12:0], 15'h0}, seed[4]);
        end
        give_verdict;
    end
endmodule
